// >>> logic/spimsp_consts.vh
// Constants for the SPI master/slave port: offsets, fields, resets, timing
// Behaviour
// - Enable bit gates all pin drive and shifting
// - Enabling never resets the control register
// - Slave select lost mid-word sets incomplete and complete
// - Software setting incomplete leaves completion flag alone
// - Polarity bit picks clock idle level
// - Edge bit with polarity picks capture edge
// - Order bit picks LSB or MSB first
// - Select pin floats unless select enable set
// - Data write while busy dropped, collision flag set
// - Completion flag set at end, reads zero busy
// - Master data write starts clock and shifting
// - Slave shifts on clocks from external master
// - Received word latched only when complete
// - Enabled idle: data out high, clock per mode
// - Keeps working whenever its clock runs and ce is high
// - Two upper control bits are plain storage
// - Mode field picks master clock source or slave
// - UART mode bit disables the SPI function
`ifndef SPIMSP_CONSTS_VH
`define SPIMSP_CONSTS_VH

// Register byte offsets on the APB
`define SPIMSP_ADDR_MODE   8'h00
`define SPIMSP_ADDR_CTRL   8'h04
`define SPIMSP_ADDR_DATA   8'h08

// Reset values
`define SPIMSP_MODE_RST    8'hE0
`define SPIMSP_CTRL_RST    8'h00
`define SPIMSP_DATA_RST    8'h00

// Mode register fields
`define SPIMSP_M_ICF       0
`define SPIMSP_M_EN        1
`define SPIMSP_M_UMD       4

// Control register fields
`define SPIMSP_C_TRF       0
`define SPIMSP_C_WRITE_COLLISION_FLAG      1
`define SPIMSP_C_SELECT_PIN_ENABLE      2
`define SPIMSP_C_ORDER     3
`define SPIMSP_C_EDGE      4
`define SPIMSP_C_POL       5

// Operating mode codes
`define SPIMSP_OM_DIV4     3'h0
`define SPIMSP_OM_DIV16    3'h1
`define SPIMSP_OM_DIV64    3'h2
`define SPIMSP_OM_SUB      3'h3
`define SPIMSP_OM_TMR      3'h4
`define SPIMSP_OM_SLAVE    3'h5

// Half SCK period minus one, in pclk cycles, per divider
`define SPIMSP_HALF_DIV4   5'h01
`define SPIMSP_HALF_DIV16  5'h07
`define SPIMSP_HALF_DIV64  5'h1F

// Word framing
`define SPIMSP_LAST_BIT    4'h7
`define SPIMSP_LAST_HEDGE  5'h0F

// Master cycles between select falling and the first clock edge
`define SPIMSP_SEL_LEAD    2'h3

`endif

// >>> logic/spimsp_sync.v
// Two flip-flop synchroniser for one asynchronous input
`default_nettype none
module spimsp_sync #(
  parameter RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire clk,
  input  wire rst_n,
  input  wire ce,
  // Data
  input  wire d_async,
  output wire q
);

  reg meta_ff;
  reg sync_ff;

  // Only the second stage is visible to the outside
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else if (ce) begin
      meta_ff <= d_async;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;

endmodule
`default_nettype wire

// >>> logic/spimsp_top.v
// SPI master/slave port with APB register access
`include "spimsp_consts.vh"
`default_nettype none
module spimsp_top (
  // Clock, reset, enable
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Alternative master clock sources
  input  wire        sub_clk_i,
  input  wire        timer_match_i,
  // Serial clock pin
  input  wire        sck_i,
  output wire        sck_o,
  output wire        sck_oe,
  // Serial data pins
  input  wire        sdi_i,
  output wire        sdo_o,
  output wire        sdo_oe,
  // Slave select pin, active low
  input  wire        scs_n_i,
  output wire        scs_n_o,
  output wire        scs_n_oe
);

  // Synchroniser reset levels: select idles high
  localparam [4:0] SYNC_RST = 5'h04;
  localparam [7:0] MODE_RST = `SPIMSP_MODE_RST;
  localparam [7:0] CTRL_RST = `SPIMSP_CTRL_RST;

  wire [4:0] raw_in;
  wire [4:0] syn;
  wire       sdi_s;
  wire       sck_s;
  wire       scs_n_s;
  wire       sub_s;
  wire       tmr_s;

  // Register state
  reg [6:0]  mode_hi_ff;
  reg        icf_ff;
  reg [5:0]  ctrl_hi_ff;
  reg        write_collision_flag_ff;
  reg        trf_ff;
  reg [7:0]  data_ff;
  // Shift engine state
  reg [7:0]  tx_ff;
  reg [7:0]  rx_ff;
  reg        busy_ff;
  reg [4:0]  hcnt_ff;
  reg [3:0]  bcnt_ff;
  reg [4:0]  div_ff;
  reg        sck_ff;
  reg        sckq_ff;
  reg        scsq_ff;
  reg        subq_ff;
  reg        tmrq_ff;
  reg [1:0]  lead_ff;
  // Pin and bus output flops
  reg        sck_oe_ff;
  reg        sdo_ff;
  reg        sdo_oe_ff;
  reg        scs_n_ff;
  reg        scs_n_oe_ff;
  reg [31:0] prdata_ff;
  reg        pready_ff;
  reg        pslverr_ff;

  // Next values
  reg [7:0]  nxt_tx;
  reg [7:0]  nxt_rx;
  reg        nxt_busy;
  reg [4:0]  nxt_hcnt;
  reg [3:0]  nxt_bcnt;
  reg [4:0]  nxt_div;
  reg        nxt_sck;
  reg [31:0] nxt_prdata;
  reg [4:0]  half_term;

  // Every pin input is brought onto pclk first
  assign raw_in = {timer_match_i, sub_clk_i, scs_n_i, sck_i, sdi_i};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
      spimsp_sync #(
        .RST_VAL (SYNC_RST[gi])
      ) u_sync (
        .clk     (pclk),
        .rst_n   (presetn),
        .ce      (ce),
        .d_async (raw_in[gi]),
        .q       (syn[gi])
      );
    end
  endgenerate

  assign sdi_s   = syn[0];
  assign sck_s   = syn[1];
  assign scs_n_s = syn[2];
  assign sub_s   = syn[3];
  assign tmr_s   = syn[4];

  // Field decode
  wire [2:0] opmode    = mode_hi_ff[6:4];
  wire       uart_mode_select       = mode_hi_ff[`SPIMSP_M_UMD - 1];
  wire       iface_en  = mode_hi_ff[`SPIMSP_M_EN - 1];
  wire       pol       = ctrl_hi_ff[`SPIMSP_C_POL - 2];
  wire       edge_sel  = ctrl_hi_ff[`SPIMSP_C_EDGE - 2];
  wire       order     = ctrl_hi_ff[`SPIMSP_C_ORDER - 2];
  wire       select_pin_enable      = ctrl_hi_ff[`SPIMSP_C_SELECT_PIN_ENABLE - 2];

  // Codes above slave and the UART mode leave the port dead
  wire is_master = (opmode < `SPIMSP_OM_SLAVE);
  wire is_slave  = (opmode == `SPIMSP_OM_SLAVE);
  wire active    = iface_en & ~uart_mode_select & (is_master | is_slave);
  wire master    = active & is_master;
  wire slave     = active & is_slave;
  wire idle_lvl  = ~pol;

  // APB decode: one wait state, effect at the completing edge
  wire acc      = psel & penable;
  wire apb_end  = acc & pready_ff;
  wire wr       = apb_end & pwrite;
  wire wr_mode  = wr & (paddr == `SPIMSP_ADDR_MODE);
  wire wr_ctrl  = wr & (paddr == `SPIMSP_ADDR_CTRL);
  wire wr_data  = wr & (paddr == `SPIMSP_ADDR_DATA);
  wire hit      = (paddr == `SPIMSP_ADDR_MODE) |
                  (paddr == `SPIMSP_ADDR_CTRL) |
                  (paddr == `SPIMSP_ADDR_DATA);

  // A data write is taken only when no word is moving
  wire start    = wr_data & ~busy_ff;
  wire collide  = wr_data & busy_ff & active;

  // Master half-period length per clock source
  always @* begin
    case (opmode)
      `SPIMSP_OM_DIV4:  half_term = `SPIMSP_HALF_DIV4;
      `SPIMSP_OM_DIV16: half_term = `SPIMSP_HALF_DIV16;
      `SPIMSP_OM_DIV64: half_term = `SPIMSP_HALF_DIV64;
      default:          half_term = `SPIMSP_HALF_DIV4;
    endcase
  end

  // Sub clock: every edge is a half period; timer: each match toggles
  wire div_hit  = (div_ff == half_term);
  wire src_tick = (opmode == `SPIMSP_OM_SUB) ? (sub_s ^ subq_ff) :
                  (opmode == `SPIMSP_OM_TMR) ? (tmr_s & ~tmrq_ff) :
                  div_hit;
  // Select must reach the far side through its synchroniser before edge one
  wire m_tick   = master & busy_ff & src_tick &
                  (lead_ff == `SPIMSP_SEL_LEAD);

  // Slave is addressed when the select pin is unused or held low
  wire sel      = ~select_pin_enable | ~scs_n_s;
  wire sck_chg  = sck_s ^ sckq_ff;
  wire s_edge   = slave & sel & sck_chg;
  wire s_lead   = (sckq_ff == idle_lvl);
  wire m_lead   = ~hcnt_ff[0];

  // Leading edge leaves idle; edge bit high means capture on it
  wire edge_evt = m_tick | s_edge;
  wire lead     = master ? m_lead : s_lead;
  wire cap      = edge_evt & (lead == edge_sel);
  wire launch   = edge_evt & (lead != edge_sel);

  // Bit order on both lines
  wire       tx_bit = order ? tx_ff[7] : tx_ff[0];
  wire [7:0] rx_in  = order ? {rx_ff[6:0], sdi_s} :
                      {sdi_s, rx_ff[7:1]};
  wire [7:0] tx_sh  = order ? {tx_ff[6:0], 1'b1} :
                      {1'b1, tx_ff[7:1]};

  // Master ends after the sixteenth half period, slave on bit eight
  wire m_end    = m_tick & (hcnt_ff == `SPIMSP_LAST_HEDGE);
  wire s_end    = slave & cap & (bcnt_ff == `SPIMSP_LAST_BIT);
  wire xfer_done = m_end | s_end;

  // Select released by the far master before the word is whole
  wire incomplete = slave & select_pin_enable & busy_ff &
                    scs_n_s & ~scsq_ff;

  // Shift engine next state
  always @* begin
    nxt_tx   = tx_ff;
    nxt_rx   = rx_ff;
    nxt_busy = busy_ff;
    nxt_hcnt = hcnt_ff;
    nxt_bcnt = bcnt_ff;
    nxt_div  = div_ff;
    nxt_sck  = sck_ff;
    if (!active) begin
      nxt_busy = 1'b0;
      nxt_hcnt = 5'h00;
      nxt_bcnt = 4'h0;
      nxt_div  = 5'h00;
      nxt_sck  = idle_lvl;
      if (start) begin
        nxt_tx = pwdata[7:0];
      end
    end else begin
      if (start) begin
        nxt_tx = pwdata[7:0];
      end
      if (start & master) begin
        nxt_busy = 1'b1;
        nxt_hcnt = 5'h00;
        nxt_div  = 5'h00;
      end
      // Clock generator only runs while a word is moving
      if (master & busy_ff) begin
        nxt_div = div_hit ? 5'h00 : div_ff + 5'h01;
        if (m_tick) begin
          nxt_sck  = ~sck_ff;
          nxt_hcnt = hcnt_ff + 5'h01;
        end
      end else begin
        nxt_sck = idle_lvl;
      end
      // First bit is already on the line before the first launch
      if (launch & (bcnt_ff != 4'h0)) begin
        nxt_tx = tx_sh;
      end
      if (cap) begin
        nxt_rx   = rx_in;
        nxt_bcnt = bcnt_ff + 4'h1;
      end
      // Only a leading edge opens a word, so the closing edge cannot
      if (s_edge & s_lead) begin
        nxt_busy = 1'b1;
      end
      if (xfer_done | incomplete | (slave & ~sel)) begin
        nxt_busy = 1'b0;
        nxt_bcnt = 4'h0;
        nxt_hcnt = 5'h00;
      end
    end
  end

  // Engine flops; all state freezes while ce is low
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ff   <= 8'hFF;
      rx_ff   <= 8'h00;
      busy_ff <= 1'b0;
      hcnt_ff <= 5'h00;
      bcnt_ff <= 4'h0;
      div_ff  <= 5'h00;
      sck_ff  <= 1'b1;
      sckq_ff <= 1'b0;
      scsq_ff <= 1'b1;
      subq_ff <= 1'b0;
      tmrq_ff <= 1'b0;
      lead_ff <= 2'h0;
    end else if (ce) begin
      // No dependency on anything but pclk and ce, so idle states keep it alive
      tx_ff   <= nxt_tx;
      rx_ff   <= nxt_rx;
      busy_ff <= nxt_busy;
      hcnt_ff <= nxt_hcnt;
      bcnt_ff <= nxt_bcnt;
      div_ff  <= nxt_div;
      sck_ff  <= nxt_sck;
      sckq_ff <= sck_s;
      scsq_ff <= scs_n_s;
      subq_ff <= sub_s;
      tmrq_ff <= tmr_s;
      lead_ff <= busy_ff ? lead_ff + {1'b0, lead_ff != `SPIMSP_SEL_LEAD} :
                 2'h0;
    end
  end

  // Mode register; enabling touches nothing in the control register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_hi_ff <= MODE_RST[7:1];
      icf_ff     <= 1'b0;
    end else if (ce) begin
      if (wr_mode) begin
        mode_hi_ff <= pwdata[7:1];
      end
      // Hardware set wins over a clearing write
      if (incomplete) begin
        icf_ff <= 1'b1;
      end else if (wr_mode) begin
        icf_ff <= pwdata[`SPIMSP_M_ICF];
      end
    end
  end

  // Control register with software-cleared flags
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_hi_ff <= CTRL_RST[7:2];
      write_collision_flag_ff    <= 1'b0;
      trf_ff     <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_hi_ff <= pwdata[7:2];
      end
      // Writing one keeps a flag; only writing zero clears it
      if (collide) begin
        write_collision_flag_ff <= 1'b1;
      end else if (wr_ctrl) begin
        write_collision_flag_ff <= write_collision_flag_ff & pwdata[`SPIMSP_C_WRITE_COLLISION_FLAG];
      end
      if (xfer_done | incomplete) begin
        trf_ff <= 1'b1;
      end else if (wr_ctrl) begin
        trf_ff <= trf_ff & pwdata[`SPIMSP_C_TRF];
      end
    end
  end

  // Readable data: whole received word or the last accepted write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_ff <= `SPIMSP_DATA_RST;
    end else if (ce) begin
      if (xfer_done) begin
        data_ff <= nxt_rx;
      end else if (start) begin
        data_ff <= pwdata[7:0];
      end
    end
  end

  // Read mux; completion flag is masked while a word is moving
  always @* begin
    nxt_prdata = 32'h0000_0000;
    case (paddr)
      `SPIMSP_ADDR_MODE: nxt_prdata[7:0] = {mode_hi_ff, icf_ff};
      `SPIMSP_ADDR_CTRL: nxt_prdata[7:0] = {ctrl_hi_ff, write_collision_flag_ff,
                                            trf_ff & ~busy_ff};
      `SPIMSP_ADDR_DATA: nxt_prdata[7:0] = data_ff;
      default:           nxt_prdata = 32'h0000_0000;
    endcase
  end

  // APB answer flops: pready rises in the second access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else if (ce) begin
      pready_ff  <= acc & ~pready_ff;
      pslverr_ff <= acc & ~pready_ff & ~hit;
      if (acc & ~pready_ff & ~pwrite) begin
        prdata_ff <= nxt_prdata;
      end
    end
  end

  // Pin drive; nothing driven while disabled so the pins can be reused
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_oe_ff   <= 1'b0;
      sdo_ff      <= 1'b1;
      sdo_oe_ff   <= 1'b0;
      scs_n_ff    <= 1'b1;
      scs_n_oe_ff <= 1'b0;
    end else if (ce) begin
      sck_oe_ff   <= master;
      sdo_oe_ff   <= active;
      // Slave with the select pin enabled presents its first bit as soon as it is selected
      sdo_ff      <= (busy_ff | (slave & select_pin_enable & ~scs_n_s)) ?
                     tx_bit : 1'b1;
      scs_n_oe_ff <= master & select_pin_enable;
      scs_n_ff    <= ~busy_ff;
    end
  end

  assign sck_o    = sck_ff;
  assign sck_oe   = sck_oe_ff;
  assign sdo_o    = sdo_ff;
  assign sdo_oe   = sdo_oe_ff;
  assign scs_n_o  = scs_n_ff;
  assign scs_n_oe = scs_n_oe_ff;
  assign prdata   = prdata_ff;
  assign pready   = pready_ff;
  assign pslverr  = pslverr_ff;

endmodule
`default_nettype wire

// >>> testbench/spimsp_props.sv
// Checker for the APB handshake and serial pin behaviour of the port
`include "spimsp_consts.vh"
`default_nettype none
module spimsp_props (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // APB
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic       pready,
  input wire logic       pslverr,
  // Serial pins
  input wire logic       sck_o,
  input wire logic       sck_oe,
  input wire logic       sdo_o,
  input wire logic       sdo_oe,
  input wire logic       scs_n_o,
  input wire logic       scs_n_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mode_m_ff;
  logic [7:0] ctrl_m_ff;
  logic [4:0] hedge_ff;
  logic       sck_q_ff;
  logic       wr_ok;
  logic [4:0] nxt_hedge;
  logic       unmapped;

  // Committed writes and half periods seen so far in a word
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  assign nxt_hedge = hedge_ff + {4'h0, sck_o != sck_q_ff};
  assign unmapped = paddr != `SPIMSP_ADDR_MODE &&
                    paddr != `SPIMSP_ADDR_CTRL && paddr != `SPIMSP_ADDR_DATA;

  // Mirror what software last wrote; the port's own state stays hidden
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_m_ff <= `SPIMSP_MODE_RST;
      ctrl_m_ff <= `SPIMSP_CTRL_RST;
      hedge_ff  <= 5'h00;
      sck_q_ff  <= 1'h1;
    end else begin
      if (wr_ok && paddr == `SPIMSP_ADDR_MODE) mode_m_ff <= pwdata[7:0];
      if (wr_ok && paddr == `SPIMSP_ADDR_CTRL) ctrl_m_ff <= pwdata[7:0];
      hedge_ff <= scs_n_o ? 5'h00 : nxt_hedge;
      sck_q_ff <= sck_o;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  ready_wait_a: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  addr_err_a: assert property (pready |-> pslverr == unmapped)
    else $error("pslverr does not match address decode");
  off_quiet_a: assert property (
    !mode_m_ff[1] [*3] |-> !sck_oe && !sdo_oe && !scs_n_oe)
    else $error("pins driven while disabled");
  uart_off_a: assert property (
    mode_m_ff[4] [*3] |-> !sck_oe && !sdo_oe)
    else $error("pins driven in uart mode");
  sel_float_a: assert property (!ctrl_m_ff[2] [*3] |-> !scs_n_oe)
    else $error("select driven with select pin disabled");
  slave_sck_a: assert property (
    (mode_m_ff[7:5] == 3'h5) [*3] |-> !sck_oe)
    else $error("clock driven in slave mode");
  idle_level_a: assert property ($past(sck_oe) && sck_oe && scs_n_oe &&
    scs_n_o && $past(scs_n_o) && $stable(ctrl_m_ff[5])
    |-> sck_o == !ctrl_m_ff[5])
    else $error("idle clock level wrong");
  sdo_idle_a: assert property (
    sdo_oe && scs_n_oe && scs_n_o && $past(scs_n_o) |-> sdo_o)
    else $error("data out not high when idle");
  word_len_a: assert property (scs_n_oe && $rose(scs_n_o) |->
    nxt_hedge == 5'h10)
    else $error("word did not have sixteen clock half periods");

  // Main scenarios reached
  cover property (scs_n_oe && $rose(scs_n_o));
  cover property (pslverr);
  cover property (mode_m_ff[7:5] == 3'h5 && mode_m_ff[1] && mode_m_ff[0]);
endmodule

bind spimsp_top spimsp_props u_spimsp_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .sck_o(sck_o), .sck_oe(sck_oe), .sdo_o(sdo_o),
  .sdo_oe(sdo_oe), .scs_n_o(scs_n_o), .scs_n_oe(scs_n_oe)
);
`default_nettype wire

// >>> testbench/spimsp_slave_model.sv
// Behavioural external SPI slave facing the port in master mode
`default_nettype none
module spimsp_slave_model (
  // Serial lines
  input  wire logic       sck,
  input  wire logic       sel_n,
  input  wire logic       mosi,
  output var  logic       miso,
  // Framing chosen by the bench
  input  wire logic       pol,
  input  wire logic       edge_sel,
  input  wire logic       msb,
  input  wire logic [7:0] tx,
  output var  logic [7:0] rx
);
  timeunit 1ns;
  timeprecision 1ns;
  int k;

  function automatic logic pick(input int i);
    pick = msb ? tx[7 - i] : tx[i];
  endfunction

  initial begin
    miso = 1'h0;
    rx = 8'h00;
    k = 0;
  end

  // Select restarts a word; leading-edge capture needs bit 0 up front
  always @(sel_n) begin
    k = 0;
    if (sel_n) miso = ~miso; // Released line never shows a stale bit
    else if (edge_sel) begin
      miso = pick(0);
      k = 1;
    end
  end

  // Capture on the active edge, launch the next bit on the other one
  always @(sck) begin
    if (!sel_n) begin
      if ((sck == pol) == edge_sel) rx = msb ? {rx[6:0], mosi}
                                             : {mosi, rx[7:1]};
      else if (k < 8) begin
        miso = pick(k);
        k = k + 1;
      end else miso = ~miso; // Hold time over
    end
  end
endmodule
`default_nettype wire

// >>> testbench/spimsp_tb_top.sv
// Self-checking bench for the SPI master/slave port
`include "spimsp_consts.vh"
`default_nettype none
module spimsp_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, ce, psel, penable, pwrite, sub_clk_i, timer_match_i;
  logic [7:0] paddr, slv_tx, m_rx;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, sck_o, sck_oe, sdo_o, sdo_oe, scs_n_o, scs_n_oe;
  logic sck_drv, scs_drv, m_pol, m_edge, m_msb, sdi_w;
  logic [3:0] div_cnt;
  wire logic sck_w, scs_w;
  int errors, comparisons;

  // Pin levels from whoever enables its driver
  assign sck_w = sck_oe ? sck_o : sck_drv;
  assign scs_w = scs_n_oe ? scs_n_o : scs_drv;

  spimsp_top u_spimsp_top (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sub_clk_i(sub_clk_i), .timer_match_i(timer_match_i), .sck_i(sck_w),
    .sck_o(sck_o), .sck_oe(sck_oe), .sdi_i(sdi_w), .sdo_o(sdo_o),
    .sdo_oe(sdo_oe), .scs_n_i(scs_w), .scs_n_o(scs_n_o),
    .scs_n_oe(scs_n_oe));

  spimsp_slave_model u_spimsp_slave_model (.sck(sck_w), .sel_n(scs_w),
    .mosi(sdo_o), .miso(sdi_w), .pol(m_pol), .edge_sel(m_edge),
    .msb(m_msb), .tx(slv_tx), .rx(m_rx));

  initial begin
    pclk = 1'h0;
    forever #10 pclk = ~pclk;
  end

  // Slow alternative clock sources for the sub and timer modes
  always @(posedge pclk) begin
    div_cnt <= (div_cnt == 4'h9) ? 4'h0 : div_cnt + 4'h1;
    if (div_cnt == 4'h9) sub_clk_i <= ~sub_clk_i;
    if (div_cnt == 4'h4) timer_match_i <= ~timer_match_i;
  end

  task automatic finish_test;
    if (errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      errors++;
      finish_test();
    end
    q = prdata[7:0];
    if (!wr) chk(pslverr, a > 8'h08);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    apb(1'h1, a, d, q);
  endtask

  // Reset values, plain storage bits, enable and uart gating
  task automatic t_reset;
    logic [7:0] q;
    apb(1'h0, `SPIMSP_ADDR_MODE, 8'h00, q);
    chk(q, 8'hE0);
    apb(1'h0, `SPIMSP_ADDR_CTRL, 8'h00, q);
    chk(q, 8'h00);
    apb(1'h0, 8'h0C, 8'h00, q);
    chk(q, 8'h00);
    chk({sck_oe, sdo_oe, scs_n_oe}, 3'h0);
    wr(`SPIMSP_ADDR_CTRL, 8'hC0);
    apb(1'h0, `SPIMSP_ADDR_CTRL, 8'h00, q);
    chk(q, 8'hC0);
    wr(`SPIMSP_ADDR_MODE, 8'h32);
    repeat (2) @(posedge pclk);
    chk({sck_oe, sdo_oe}, 2'h0);
    wr(`SPIMSP_ADDR_MODE, 8'h02);
    repeat (2) @(posedge pclk);
    chk({sck_oe, sdo_oe}, 2'h3);
    wr(`SPIMSP_ADDR_MODE, 8'h00);
  endtask

  // Setup, enable, write, collide, poll, read, clear
  task automatic t_master(input logic [2:0] om, input logic pol, edg, msb,
                          input logic [7:0] tx, rxv);
    logic [7:0] q, c;
    int n;
    c = {2'h0, pol, edg, msb, 3'h4};
    m_pol <= pol;
    m_edge <= edg;
    m_msb <= msb;
    slv_tx <= rxv;
    wr(`SPIMSP_ADDR_MODE, {om, 5'h00});
    wr(`SPIMSP_ADDR_CTRL, c);
    wr(`SPIMSP_ADDR_MODE, {om, 5'h02});
    apb(1'h0, `SPIMSP_ADDR_CTRL, 8'h00, q);
    chk(q, c);
    chk({sck_oe, sck_o, sdo_oe, sdo_o}, {1'h1, ~pol, 2'h3});
    wr(`SPIMSP_ADDR_DATA, tx);
    wr(`SPIMSP_ADDR_DATA, ~tx);
    apb(1'h0, `SPIMSP_ADDR_CTRL, 8'h00, q);
    chk(q, c | 8'h02);
    n = 0;
    do begin
      apb(1'h0, `SPIMSP_ADDR_CTRL, 8'h00, q);
      n++;
    end while (q[0] !== 1'h1 && n < 400);
    chk(q, c | 8'h03);
    if (q[0] !== 1'h1) finish_test();
    apb(1'h0, `SPIMSP_ADDR_DATA, 8'h00, q);
    chk(q, rxv);
    chk(m_rx, tx);
    wr(`SPIMSP_ADDR_CTRL, c);
    apb(1'h0, `SPIMSP_ADDR_CTRL, 8'h00, q);
    chk(q, c);
  endtask

  // Whole slave word clocked by the bench, model answering on sdi
  task automatic t_slave(input logic [7:0] tx, rxv);
    logic [7:0] q;
    m_pol <= 1'h0;
    m_edge <= 1'h1;
    m_msb <= 1'h1;
    slv_tx <= rxv;
    wr(`SPIMSP_ADDR_MODE, 8'hA0);
    wr(`SPIMSP_ADDR_CTRL, 8'h1C);
    wr(`SPIMSP_ADDR_MODE, 8'hA2);
    wr(`SPIMSP_ADDR_DATA, tx);
    scs_drv <= 1'h0;
    repeat (16) begin
      repeat (10) @(posedge pclk);
      sck_drv <= ~sck_drv;
    end
    repeat (10) @(posedge pclk);
    scs_drv <= 1'h1;
    repeat (10) @(posedge pclk);
    apb(1'h0, `SPIMSP_ADDR_MODE, 8'h00, q);
    chk(q, 8'hA2);
    apb(1'h0, `SPIMSP_ADDR_CTRL, 8'h00, q);
    chk(q, 8'h1D);
    apb(1'h0, `SPIMSP_ADDR_DATA, 8'h00, q);
    chk(q, rxv);
    chk(m_rx, tx);
  endtask

  // Slave word cut short by the master releasing select
  task automatic t_abort;
    logic [7:0] q;
    wr(`SPIMSP_ADDR_MODE, 8'hA0);
    wr(`SPIMSP_ADDR_CTRL, 8'h0C);
    wr(`SPIMSP_ADDR_MODE, 8'hA2);
    repeat (2) @(posedge pclk);
    chk({sck_oe, scs_n_oe}, 2'h0);
    scs_drv <= 1'h0;
    repeat (6) begin
      repeat (10) @(posedge pclk);
      sck_drv <= ~sck_drv;
    end
    repeat (10) @(posedge pclk);
    scs_drv <= 1'h1;
    repeat (10) @(posedge pclk);
    apb(1'h0, `SPIMSP_ADDR_MODE, 8'h00, q);
    chk(q, 8'hA3);
    apb(1'h0, `SPIMSP_ADDR_CTRL, 8'h00, q);
    chk(q, 8'h0D);
    wr(`SPIMSP_ADDR_CTRL, 8'h0C);
    wr(`SPIMSP_ADDR_MODE, 8'hA2);
    wr(`SPIMSP_ADDR_MODE, 8'hA3);
    apb(1'h0, `SPIMSP_ADDR_CTRL, 8'h00, q);
    chk(q, 8'h0C);
  endtask

  initial begin
    presetn = 1'h0;
    ce = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    sub_clk_i = 1'h0;
    timer_match_i = 1'h0;
    div_cnt = 4'h0;
    sck_drv = 1'h1;
    scs_drv = 1'h1;
    m_pol = 1'h0;
    m_edge = 1'h0;
    m_msb = 1'h0;
    slv_tx = 8'h00;
    errors = 0;
    comparisons = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    repeat (2) @(posedge pclk);
    t_reset();
    t_master(`SPIMSP_OM_DIV16, 1'h0, 1'h0, 1'h0, 8'hA5, 8'h3C);
    t_master(`SPIMSP_OM_DIV64, 1'h0, 1'h1, 1'h1, 8'h81, 8'h7E);
    t_master(`SPIMSP_OM_SUB, 1'h1, 1'h0, 1'h1, 8'h5A, 8'hC3);
    t_master(`SPIMSP_OM_TMR, 1'h1, 1'h1, 1'h0, 8'h01, 8'hF0);
    t_slave(8'h96, 8'h2D);
    t_abort();
    finish_test();
  end
endmodule
`default_nettype wire
